// ### pkg/key_wake_pkg.sv
// Package: register map, field positions and reset values of the key wakeup block
package key_wake_pkg;
    localparam int NUM_PINS = 8;
    localparam logic [11:0] STATUS_CONTROL_OFFS = 12'h000;
    localparam logic [11:0] PIN_ENABLE_OFFS = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFFS = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFFS = 12'h00C;
    localparam int MODE_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    localparam int ACK_BIT = 2;
    localparam int FLAG_BIT = 3;
    localparam int POL_LSB = 4;
    localparam int POL_W = 4;
    localparam int EVT_EDGE_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;
    localparam int EVT_W = 2;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [3:0] POL_RST = 4'h0;
    localparam logic [1:0] EVT_RST = 2'h0;

    typedef struct packed {
        logic [3:0] pol;
        logic irq_en;
        logic mode;
    } key_ctrl_t;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } bus_req_t;
endpackage

// ### design/key_pin_sync.sv
// Two-stage synchroniser for the key pins
`timescale 1ns/100ps
module key_pin_sync
    import key_wake_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [NUM_PINS-1:0] i_pins,
    output logic [NUM_PINS-1:0] o_pins
);
    logic [NUM_PINS-1:0] meta_r;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            meta_r <= '1;
            o_pins <= '1;
        end else begin
            meta_r <= i_pins;
            o_pins <= meta_r;
        end
    end
endmodule

// ### design/key_wake_irq.sv
// Key wakeup interrupt controller with APB registers
//
// What this block does
// - Edge needs prior deasserted sample first
// - Falling edge: high then low sample
// - Rising edge: low then high sample
// - Level mode: flag on first asserting pin
// - Level mode: flag held while asserted
// - Stop mode: asynchronous level wake output
// - Interrupt request while flag and enable
// - Edge mode: ack write clears flag
// - Ack bit 2, write-only, reads zero
// - Bits 7:4 polarity for upper pins
// - Pins 3:0 fixed falling or low
// - Flag bit 3, read-only, event pending
// - Enable bit 1; flag still pollable
// - Bit 0 selects edge or level mode
// - Pin enable mask, one bit per pin
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
module key_wake_irq
    import key_wake_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_PINS-1:0] i_key_pins,
    input wire logic i_stop_mode,
    output logic o_key_irq,
    output logic o_stop_wake,
    output logic o_irq
);
    key_ctrl_t ctrl_r;
    logic [NUM_PINS-1:0] pin_watch_enable_r;
    logic key_event_flag_r;
    logic [NUM_PINS-1:0] pins_s;
    logic [NUM_PINS-1:0] prev_r;
    logic [NUM_PINS-1:0] asserted;
    logic [NUM_PINS-1:0] prev_asserted;
    logic [NUM_PINS-1:0] pol_full;
    logic edge_evt;
    logic any_level;
    logic ack_wr;
    logic [EVT_W-1:0] evt_status_r;
    logic [EVT_W-1:0] evt_mask_r;
    logic [EVT_W-1:0] evt_set;
    logic stop_wake_d_r;
    bus_req_t req;

    function automatic logic [NUM_PINS-1:0] to_asserted(input logic [NUM_PINS-1:0] lvl,
                                                       input logic [NUM_PINS-1:0] pol,
                                                       input logic [NUM_PINS-1:0] en);
        to_asserted = ~(lvl ^ pol) & en;
    endfunction

    key_pin_sync u_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_pins(i_key_pins),
        .o_pins(pins_s)
    );

    always_comb begin
        req.addr = i_paddr;
        req.wr = i_psel && i_penable && i_pwrite;
        req.rd = i_psel && !i_pwrite;
        req.wdata = i_pwdata;
    end

    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;

    // Polarity: upper from register, lower fixed low-active
    assign pol_full = {ctrl_r.pol, 4'h0};
    assign asserted = to_asserted(pins_s, pol_full, pin_watch_enable_r);
    assign prev_asserted = to_asserted(prev_r, pol_full, pin_watch_enable_r);
    // Edge only from deasserted previous sample, none else asserted before
    assign edge_evt = |(asserted & ~prev_asserted) && (prev_asserted == '0);
    assign any_level = |asserted;
    assign ack_wr = req.wr && req.addr == STATUS_CONTROL_OFFS && req.wdata[ACK_BIT];

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            prev_r <= '1;
        end else begin
            prev_r <= pins_s;
        end
    end

    // Register writes
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ctrl_r <= '{pol: POL_RST, irq_en: 1'b0, mode: 1'b0};
            pin_watch_enable_r <= ENABLE_RST;
            evt_mask_r <= EVT_RST;
        end else if (req.wr) begin
            if (req.addr == STATUS_CONTROL_OFFS) begin
                ctrl_r.pol <= req.wdata[POL_LSB +: POL_W];
                ctrl_r.irq_en <= req.wdata[IRQ_EN_BIT];
                ctrl_r.mode <= req.wdata[MODE_BIT];
            end
            if (req.addr == PIN_ENABLE_OFFS) begin
                pin_watch_enable_r <= req.wdata[NUM_PINS-1:0];
            end
            if (req.addr == IRQ_MASK_OFFS) begin
                evt_mask_r <= req.wdata[EVT_W-1:0];
            end
        end
    end

    // Event flag: set wins over acknowledge
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            key_event_flag_r <= 1'b0;
        end else if (edge_evt || (ctrl_r.mode && any_level)) begin
            key_event_flag_r <= 1'b1;
        end else if (ack_wr) begin
            key_event_flag_r <= 1'b0;
        end
    end

    assign o_key_irq = key_event_flag_r && ctrl_r.irq_en;

    // Stop mode: raw pin levels, no clock needed
    assign o_stop_wake = i_stop_mode && |(~(i_key_pins ^ pol_full) & pin_watch_enable_r);

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            stop_wake_d_r <= 1'b0;
        end else begin
            stop_wake_d_r <= i_stop_mode && any_level;
        end
    end

    assign evt_set[EVT_EDGE_BIT] = edge_evt;
    assign evt_set[EVT_WAKE_BIT] = i_stop_mode && any_level && !stop_wake_d_r;

    // Sticky status, write one to clear, set wins
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            evt_status_r <= EVT_RST;
        end else if (req.wr && req.addr == IRQ_STATUS_OFFS) begin
            evt_status_r <= (evt_status_r & ~req.wdata[EVT_W-1:0]) | evt_set;
        end else begin
            evt_status_r <= evt_status_r | evt_set;
        end
    end

    assign o_irq = |(evt_status_r & evt_mask_r);

    // Read data register
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0000_0000;
        end else if (req.rd && !i_penable) begin
            unique case (req.addr)
                STATUS_CONTROL_OFFS: o_prdata <= {24'h00_0000, ctrl_r.pol, key_event_flag_r, 1'b0,
                                                  ctrl_r.irq_en, ctrl_r.mode};
                PIN_ENABLE_OFFS: o_prdata <= {24'h00_0000, pin_watch_enable_r};
                IRQ_STATUS_OFFS: o_prdata <= {30'h0000_0000, evt_status_r};
                IRQ_MASK_OFFS: o_prdata <= {30'h0000_0000, evt_mask_r};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    a_flag_irq_tie: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_key_irq == (key_event_flag_r && ctrl_r.irq_en)) else $error("irq not tied to flag");
    a_level_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        ctrl_r.mode && any_level |=> key_event_flag_r) else $error("level flag not held");
    a_edge_ack_clr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        ack_wr && !ctrl_r.mode && !edge_evt |=> !key_event_flag_r) else $error("ack did not clear");
    a_fall_detect: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        pin_watch_enable_r[0] && $past(pins_s[0]) && !pins_s[0] && prev_asserted == '0
        |=> key_event_flag_r) else $error("falling edge missed");
    a_rise_detect: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        pin_watch_enable_r[7] && ctrl_r.pol[3] && !prev_r[7] && pins_s[7] && prev_asserted == '0
        |=> key_event_flag_r) else $error("rising edge missed");
    a_disabled_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        pin_watch_enable_r == '0 && !key_event_flag_r |=> !key_event_flag_r) else $error("flag from disabled pins");
    a_no_edge_held: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        prev_asserted != '0 |-> !edge_evt) else $error("edge without deasserted start");
    a_ack_reads_0: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $past(req.rd && !i_penable && req.addr == STATUS_CONTROL_OFFS) |-> !o_prdata[ACK_BIT])
        else $error("ack bit read as one");
endmodule

// ### verif/key_pad_model.sv
// Keypad switch model driving the key pins
`timescale 1ns/100ps
module key_pad_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_press,
    input wire logic [3:0] i_pol,
    output logic [7:0] o_pins
);
    // Open keys rest at the deasserted level, pins 3:0 high when open and low when pressed
    always @(posedge i_mclk) begin
        o_pins <= i_press ~^ {i_pol, 4'h0};
    end
endmodule

// ### verif/keypad_wakeup_interrupt_tb_top.sv
// Testbench for the key wakeup interrupt block
`timescale 1ns/100ps
module keypad_wakeup_interrupt_tb_top;
    import key_wake_pkg::*;
    logic i_mclk = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0, stop = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, key_irq, wake, irq;
    logic [7:0] press = 8'h00, pins;
    logic [3:0] pol = 4'h0;
    int failures = 0, check_count = 0, cyc = 0, k, idx;
    always #4 i_mclk = ~i_mclk;
    key_pad_model u_keys (.i_mclk(i_mclk), .i_press(press), .i_pol(pol), .o_pins(pins));
    key_wake_irq u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_key_pins(pins), .i_stop_mode(stop), .o_key_irq(key_irq),
        .o_stop_wake(wake), .o_irq(irq));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(q, e);
        check(32'(pslverr), 32'h0);
    endtask
    task keys(input logic [7:0] p);
        press <= p;
        repeat (6) @(posedge i_mclk);
    endtask
    task stop_test;
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test;
        end
    end
    initial begin
        void'($urandom(32'h3D7ACB3C));
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        $display("reset done");
        wr(12'h004, 32'hFF);
        wr(12'h000, 32'h02);
        for (k = 0; k < 4; k++) begin
            idx = $urandom_range(7, 0);
            keys(8'h01 << idx);
            rd(12'h000, 32'h0A);
            check(32'(key_irq), 32'h1);
            wr(12'h000, 32'h06);
            rd(12'h000, 32'h02);
            keys(8'h00);
            rd(12'h000, 32'h02);
        end
        wr(12'h000, 32'hF2);
        pol <= 4'hF;
        keys(8'h00);
        wr(12'h000, 32'hF6);
        keys(8'h80);
        rd(12'h000, 32'hFA);
        wr(12'h000, 32'hF6);
        keys(8'h00);
        wr(12'h004, 32'h01);
        keys(8'h80);
        rd(12'h000, 32'hF2);
        wr(12'h004, 32'h00);
        keys(8'h01);
        wr(12'h004, 32'h01);
        keys(8'h01);
        rd(12'h000, 32'hF2);
        keys(8'h00);
        $display("edge done");
        wr(12'h000, 32'hF3);
        keys(8'h01);
        rd(12'h000, 32'hFB);
        wr(12'h000, 32'hF7);
        rd(12'h000, 32'hFB);
        keys(8'h00);
        wr(12'h000, 32'hF4);
        keys(8'h01);
        rd(12'h000, 32'hF8);
        check(32'(key_irq), 32'h0);
        keys(8'h00);
        $display("level done");
        rd(12'h008, 32'h1);
        check(32'(irq), 32'h0);
        wr(12'h00C, 32'h3);
        rd(12'h00C, 32'h3);
        check(32'(irq), 32'h1);
        wr(12'h00C, 32'h0);
        wr(12'h008, 32'h1);
        rd(12'h008, 32'h0);
        check(32'(irq), 32'h0);
        wr(12'h010, 32'hFFFFFFFF);
        rd(12'h010, 32'h0);
        $display("irq done");
        wr(12'h000, 32'hF4);
        stop <= 1'b1;
        keys(8'h01);
        check(32'(wake), 32'h1);
        stop <= 1'b0;
        keys(8'h00);
        $display("stop done");
        stop_test;
    end
endmodule
